// ==== common/vcg_pkg.sv ====
// Register map, field layout, states and carriers of the video clock genlock register bank
package vcg_pkg;
  localparam logic [7:0] ADDR_STATUS   = 8'h01;
  localparam logic [7:0] ADDR_POLARITY = 8'h02;
  localparam logic [7:0] ADDR_REF_DIV  = 8'h03;
  localparam logic [7:0] ADDR_FB_LOW   = 8'h04;
  localparam logic [7:0] ADDR_FB_HIGH  = 8'h05;
  localparam logic [7:0] ADDR_PUMP     = 8'h06;
  localparam logic [7:0] ADDR_RSVD     = 8'h07;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_TOF_LOW  = 8'h09;
  localparam logic [7:0] ADDR_ALIGN    = 8'h0a;
  localparam int unsigned NUM_REGS     = 11;

  // Reset values, index 10 first
  localparam logic [NUM_REGS-1:0][7:0] RST_REGS = {
    8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h06, 8'hb4, 8'h01, 8'h00, 8'h86, 8'h00};

  // Writable bits per register
  localparam logic [7:0] WMASK_STATUS   = 8'hf8;
  localparam logic [7:0] WMASK_POLARITY = 8'h3f;
  localparam logic [7:0] WMASK_REF_DIV  = 8'h03;
  localparam logic [7:0] WMASK_FULL     = 8'hff;
  localparam logic [7:0] WMASK_FB_HIGH  = 8'h1f;
  localparam logic [7:0] WMASK_PUMP     = 8'h0f;
  localparam logic [7:0] WMASK_OUT_CTRL = 8'h3f;

  localparam int unsigned BIT_REF_VALID  = 0;
  localparam int unsigned BIT_STANDARD_DEF_PLL_LOCKED    = 1;
  localparam int unsigned BIT_HIGH_DEF_PLL_LOCKED    = 2;
  localparam int unsigned LSB_LOCK_THR   = 3;
  localparam int unsigned BIT_VSYNC_B_POLARITY     = 0;
  localparam int unsigned BIT_HSYNC_B_POLARITY     = 1;
  localparam int unsigned BIT_VSYNC_A_POLARITY     = 2;
  localparam int unsigned BIT_HSYNC_A_POLARITY     = 3;
  localparam int unsigned BIT_CLK_REF    = 4;
  localparam int unsigned BIT_PIN_OVRD   = 5;
  localparam int unsigned BIT_PUMP_INV   = 3;
  localparam int unsigned BIT_SD_RATE    = 0;
  localparam int unsigned BIT_SD_FLOAT   = 1;
  localparam int unsigned LSB_HD_RATE    = 2;
  localparam int unsigned BIT_HD_FLOAT   = 4;
  localparam int unsigned BIT_TOF_FLOAT  = 5;
  localparam int unsigned BIT_ALIGN_INIT = 5;
  localparam int unsigned BIT_TOF_POL    = 6;
  localparam int unsigned BIT_ALIGN_EN   = 7;

  // Edge detector lanes
  localparam int unsigned EDGE_LANES = 5;
  localparam int unsigned LANE_SCL   = 0;
  localparam int unsigned LANE_SDA   = 1;
  localparam int unsigned LANE_HSYNC = 2;
  localparam int unsigned LANE_VSYNC = 3;
  localparam int unsigned LANE_PIN   = 4;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2d;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX   = 6'h04,
    ST_ACK  = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } vcg_i2c_st_e;

  typedef struct packed {
    logic hsync_input_a;
    logic vsync_a;
    logic hsync_input_b;
    logic vsync_b;
  } vcg_sync_s;

  typedef struct packed {
    logic       standard_def_rate_select;
    logic       standard_def_output_float;
    logic [1:0] high_def_rate_select;
    logic       high_def_output_float;
  } vcg_outclk_s;

  typedef struct packed {
    vcg_i2c_st_e                 st;
    logic [3:0]                  bit_cnt;
    logic [7:0]                  shreg;
    logic                        rw;
    logic                        first;
    logic [7:0]                  ptr;
    logic                        sda_drv;
    logic [NUM_REGS-1:0][7:0]    regs;
    logic                        ref_valid;
    logic                        standard_def_pll_locked;
    logic                        high_def_pll_locked;
    logic                        ref_b;
    logic                        align_init;
    logic                        h_edge;
    logic                        h_rst;
    logic                        v_rst;
    logic                        frame_start_pulse_out;
  } vcg_main_s;
endpackage

// ==== verilog/vcg_edge_det.sv ====
// Registered level and edge detector for a group of synchronous inputs
`timescale 1ns/1ps
module vcg_edge_det #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] sig_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cur;
    logic [WIDTH-1:0] old;
    logic             vld;
  } vcg_edge_s;

  vcg_edge_s r;
  vcg_edge_s n;

  if (WIDTH < 1) begin : g_chk
    $error("vcg_edge_det needs at least one lane");
  end

  always_comb begin
    n     = r;
    n.cur = sig_i;
    // First sample after reset makes no edge
    n.old = r.vld ? r.cur : sig_i;
    n.vld = 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  assign level_o = r.cur;
  assign rise_o  = r.cur & ~r.old;
  assign fall_o  = ~r.cur & r.old;
endmodule

// ==== verilog/vcg_ref_mux.sv ====
// Reference port selection and sync polarity normalisation
`timescale 1ns/1ps
module vcg_ref_mux (
  input  wire logic                 select_pin_i,
  input  wire logic                 select_pin_override_i,
  input  wire logic                 serial_reference_select_enable_i,
  input  wire logic                 reg_select_b_i,
  input  wire logic [3:0]           polarity_i,
  input  wire vcg_pkg::vcg_sync_s   sync_i,
  output logic                      ref_b_o,
  output logic                      hsync_active_o,
  output logic                      vsync_active_o
);
  always_comb begin
    // Pin level selects only when neither override nor serial control
    if (select_pin_override_i || serial_reference_select_enable_i) begin
      ref_b_o = reg_select_b_i;
    end else begin
      ref_b_o = select_pin_i;
    end
    // Polarity bit one means active high
    if (ref_b_o) begin
      hsync_active_o = sync_i.hsync_input_b ~^ polarity_i[vcg_pkg::BIT_HSYNC_B_POLARITY];
      vsync_active_o = sync_i.vsync_b ~^ polarity_i[vcg_pkg::BIT_VSYNC_B_POLARITY];
    end else begin
      hsync_active_o = sync_i.hsync_input_a ~^ polarity_i[vcg_pkg::BIT_HSYNC_A_POLARITY];
      vsync_active_o = sync_i.vsync_a ~^ polarity_i[vcg_pkg::BIT_VSYNC_A_POLARITY];
    end
  end
endmodule

// ==== verilog/vcg_regs.sv ====
// Serial register bank of the video clock generator with genlock
`timescale 1ns/1ps
module vcg_regs #(
  parameter logic [6:0] SLAVE_ADDR = vcg_pkg::DEFAULT_SLAVE_ADDR
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 i2c_enable_n_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  input  wire logic                 genlock_mode_i,
  input  wire logic                 ref_present_i,
  input  wire logic                 sd_pll_locked_i,
  input  wire logic                 hd_pll_locked_i,
  input  wire logic                 serial_reference_select_enable_i,
  input  wire logic                 reference_select_reg_i,
  input  wire logic                 select_pin_i,
  input  wire vcg_pkg::vcg_sync_s   sync_i,
  input  wire logic                 frame_start_i,
  output logic                      no_reference_o,
  output logic                      reference_select_b_o,
  output logic [4:0]                lock_threshold_o,
  output logic                      clock_reference_mode_o,
  output logic [1:0]                reference_divider_o,
  output logic [12:0]               feedback_divider_value_o,
  output logic [3:0]                sd_pll_pump_current_o,
  output vcg_pkg::vcg_outclk_s      out_clk_ctrl_o,
  output logic [12:0]               frame_counter_reset_ratio_o,
  output logic                      alignment_mode_enable_o,
  output logic                      alignment_init_trigger_o,
  output logic                      hsync_active_edge_o,
  output logic                      frame_counter_h_reset_o,
  output logic                      frame_counter_v_reset_o,
  output logic                      frame_start_pulse_out_o,
  output logic                      frame_start_pulse_oe_o
);
  vcg_pkg::vcg_main_s                 r;
  vcg_pkg::vcg_main_s                 n;
  logic [vcg_pkg::EDGE_LANES-1:0]     e_lvl;
  logic [vcg_pkg::EDGE_LANES-1:0]     e_rise;
  logic [vcg_pkg::EDGE_LANES-1:0]     e_fall;
  logic                               mux_ref_b;
  logic                               hsync_act;
  logic                               vsync_act;
  logic                               bus_start;
  logic                               bus_stop;
  logic [7:0]                         status_rd;
  logic [7:0]                         fb_high_rd;
  logic [7:0]                         rsvd_rd;
  logic [7:0]                         pump_rd;

  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("vcg_regs slave address must not be the general call address");
  end

  // Writable bits of each offset
  function automatic logic [7:0] wmask(input logic [7:0] a);
    unique case (a)
      vcg_pkg::ADDR_STATUS:   wmask = vcg_pkg::WMASK_STATUS;
      vcg_pkg::ADDR_POLARITY: wmask = vcg_pkg::WMASK_POLARITY;
      vcg_pkg::ADDR_REF_DIV:  wmask = vcg_pkg::WMASK_REF_DIV;
      vcg_pkg::ADDR_FB_LOW:   wmask = vcg_pkg::WMASK_FULL;
      vcg_pkg::ADDR_FB_HIGH:  wmask = vcg_pkg::WMASK_FB_HIGH;
      vcg_pkg::ADDR_PUMP:     wmask = vcg_pkg::WMASK_PUMP;
      vcg_pkg::ADDR_OUT_CTRL: wmask = vcg_pkg::WMASK_OUT_CTRL;
      vcg_pkg::ADDR_TOF_LOW:  wmask = vcg_pkg::WMASK_FULL;
      vcg_pkg::ADDR_ALIGN:    wmask = vcg_pkg::WMASK_FULL;
      default:                wmask = 8'h00;
    endcase
  endfunction

  // Byte returned for a read at an offset
  function automatic logic [7:0] read_byte(input vcg_pkg::vcg_main_s s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a >= vcg_pkg::ADDR_STATUS && a <= vcg_pkg::ADDR_ALIGN) begin
      d = s.regs[a[3:0]] & wmask(a);
    end
    if (a == vcg_pkg::ADDR_STATUS) begin
      d[vcg_pkg::BIT_REF_VALID] = s.ref_valid;
      d[vcg_pkg::BIT_STANDARD_DEF_PLL_LOCKED]   = s.standard_def_pll_locked;
      d[vcg_pkg::BIT_HIGH_DEF_PLL_LOCKED]   = s.high_def_pll_locked;
    end
    return d;
  endfunction

  vcg_edge_det #(
    .WIDTH (vcg_pkg::EDGE_LANES)
  ) u_edge (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .sig_i     ({select_pin_i, vsync_act, hsync_act, sda_i, scl_i}),
    .level_o   (e_lvl),
    .rise_o    (e_rise),
    .fall_o    (e_fall)
  );

  vcg_ref_mux u_mux (
    .select_pin_i                     (select_pin_i),
    .select_pin_override_i            (r.regs[vcg_pkg::ADDR_POLARITY[3:0]][vcg_pkg::BIT_PIN_OVRD]),
    .serial_reference_select_enable_i (serial_reference_select_enable_i),
    .reg_select_b_i                   (reference_select_reg_i),
    .polarity_i                       (r.regs[vcg_pkg::ADDR_POLARITY[3:0]][3:0]),
    .sync_i                           (sync_i),
    .ref_b_o                          (mux_ref_b),
    .hsync_active_o                   (hsync_act),
    .vsync_active_o                   (vsync_act)
  );

  assign bus_start = e_fall[vcg_pkg::LANE_SDA] & e_lvl[vcg_pkg::LANE_SCL];
  assign bus_stop  = e_rise[vcg_pkg::LANE_SDA] & e_lvl[vcg_pkg::LANE_SCL];

  always_comb begin
    logic [7:0] rd;
    logic [3:0] idx;
    logic       pin_ovrd;
    logic       align_en;
    rd         = read_byte(r, r.ptr);
    idx        = r.ptr[3:0];
    pin_ovrd   = r.regs[vcg_pkg::ADDR_POLARITY[3:0]][vcg_pkg::BIT_PIN_OVRD];
    align_en   = r.regs[vcg_pkg::ADDR_ALIGN[3:0]][vcg_pkg::BIT_ALIGN_EN];
    n          = r;
    n.ref_valid = genlock_mode_i & ref_present_i;
    n.standard_def_pll_locked  = sd_pll_locked_i;
    n.high_def_pll_locked  = hd_pll_locked_i;
    n.ref_b    = mux_ref_b;
    n.h_edge   = e_rise[vcg_pkg::LANE_HSYNC];
    n.h_rst    = e_rise[vcg_pkg::LANE_HSYNC] & r.ref_valid & r.standard_def_pll_locked;
    n.v_rst    = e_rise[vcg_pkg::LANE_VSYNC] & r.ref_valid & r.standard_def_pll_locked;
    n.frame_start_pulse_out      = frame_start_i ~^ r.regs[vcg_pkg::ADDR_ALIGN[3:0]][vcg_pkg::BIT_TOF_POL];
    n.align_init = pin_ovrd & align_en & e_rise[vcg_pkg::LANE_PIN];
    if (i2c_enable_n_i) begin
      n.st      = vcg_pkg::ST_IDLE;
      n.sda_drv = 1'b0;
    end else if (bus_start) begin
      n.st      = vcg_pkg::ST_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_drv = 1'b0;
    end else if (bus_stop) begin
      n.st      = vcg_pkg::ST_IDLE;
      n.sda_drv = 1'b0;
    end else begin
      unique case (r.st)
        vcg_pkg::ST_IDLE: begin
          n.sda_drv = 1'b0;
        end
        vcg_pkg::ST_ADDR, vcg_pkg::ST_RX: begin
          if (e_rise[vcg_pkg::LANE_SCL]) begin
            n.shreg   = {r.shreg[6:0], e_lvl[vcg_pkg::LANE_SDA]};
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (e_fall[vcg_pkg::LANE_SCL] && r.bit_cnt == vcg_pkg::BITS_PER_BYTE) begin
            n.st      = vcg_pkg::ST_ACK;
            n.sda_drv = 1'b1;
            if (r.st == vcg_pkg::ST_ADDR) begin
              if (r.shreg[7:1] == SLAVE_ADDR) begin
                n.rw    = r.shreg[0];
                n.first = ~r.shreg[0];
              end else begin
                n.st      = vcg_pkg::ST_IDLE;
                n.sda_drv = 1'b0;
              end
            end else if (r.first) begin
              n.ptr   = r.shreg;
              n.first = 1'b0;
            end else begin
              if (r.ptr >= vcg_pkg::ADDR_STATUS && r.ptr <= vcg_pkg::ADDR_ALIGN) begin
                n.regs[idx] = (r.regs[idx] & ~wmask(r.ptr)) | (r.shreg & wmask(r.ptr));
              end
              if (r.ptr == vcg_pkg::ADDR_ALIGN && r.shreg[vcg_pkg::BIT_ALIGN_INIT]
                  && !r.regs[idx][vcg_pkg::BIT_ALIGN_INIT]) begin
                n.align_init = 1'b1;
              end
              n.ptr = r.ptr + 8'h01;
            end
          end
        end
        vcg_pkg::ST_ACK: begin
          if (e_fall[vcg_pkg::LANE_SCL]) begin
            n.bit_cnt = 4'h0;
            if (r.rw) begin
              n.st      = vcg_pkg::ST_TX;
              n.shreg   = rd;
              n.sda_drv = ~rd[7];
            end else begin
              n.st      = vcg_pkg::ST_RX;
              n.sda_drv = 1'b0;
            end
          end
        end
        vcg_pkg::ST_TX: begin
          if (e_rise[vcg_pkg::LANE_SCL]) begin
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (e_fall[vcg_pkg::LANE_SCL]) begin
            if (r.bit_cnt == vcg_pkg::BITS_PER_BYTE) begin
              n.st      = vcg_pkg::ST_MACK;
              n.sda_drv = 1'b0;
              n.ptr     = r.ptr + 8'h01;
            end else begin
              n.shreg   = {r.shreg[6:0], 1'b0};
              n.sda_drv = ~r.shreg[6];
            end
          end
        end
        vcg_pkg::ST_MACK: begin
          if (e_rise[vcg_pkg::LANE_SCL] && e_lvl[vcg_pkg::LANE_SDA]) begin
            n.st = vcg_pkg::ST_IDLE;
          end else if (e_fall[vcg_pkg::LANE_SCL]) begin
            n.st      = vcg_pkg::ST_TX;
            n.bit_cnt = 4'h0;
            n.shreg   = rd;
            n.sda_drv = ~rd[7];
          end
        end
        default: begin
          n.st      = vcg_pkg::ST_IDLE;
          n.sda_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r      <= '0;
      r.st   <= vcg_pkg::ST_IDLE;
      r.regs <= vcg_pkg::RST_REGS;
      r.frame_start_pulse_out  <= 1'b1;
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  assign sda_o                    = 1'b0;
  assign sda_oe_o                 = r.sda_drv;
  assign no_reference_o           = ~r.ref_valid;
  assign reference_select_b_o     = r.ref_b;
  assign lock_threshold_o         = r.regs[vcg_pkg::ADDR_STATUS[3:0]][7:vcg_pkg::LSB_LOCK_THR];
  assign clock_reference_mode_o   = r.regs[vcg_pkg::ADDR_POLARITY[3:0]][vcg_pkg::BIT_CLK_REF];
  assign reference_divider_o      = r.regs[vcg_pkg::ADDR_REF_DIV[3:0]][1:0];
  assign feedback_divider_value_o = {r.regs[vcg_pkg::ADDR_FB_HIGH[3:0]][4:0], r.regs[vcg_pkg::ADDR_FB_LOW[3:0]]};
  assign sd_pll_pump_current_o    = r.regs[vcg_pkg::ADDR_PUMP[3:0]][3:0]
                                    ^ 4'h8;
  assign out_clk_ctrl_o.standard_def_rate_select  =
    r.regs[vcg_pkg::ADDR_OUT_CTRL[3:0]][vcg_pkg::BIT_SD_RATE];
  assign out_clk_ctrl_o.standard_def_output_float =
    r.regs[vcg_pkg::ADDR_OUT_CTRL[3:0]][vcg_pkg::BIT_SD_FLOAT];
  assign out_clk_ctrl_o.high_def_rate_select      =
    r.regs[vcg_pkg::ADDR_OUT_CTRL[3:0]][vcg_pkg::LSB_HD_RATE+1:vcg_pkg::LSB_HD_RATE];
  assign out_clk_ctrl_o.high_def_output_float     =
    r.regs[vcg_pkg::ADDR_OUT_CTRL[3:0]][vcg_pkg::BIT_HD_FLOAT];
  assign frame_counter_reset_ratio_o =
    {r.regs[vcg_pkg::ADDR_ALIGN[3:0]][4:0], r.regs[vcg_pkg::ADDR_TOF_LOW[3:0]]};
  assign alignment_mode_enable_o  = r.regs[vcg_pkg::ADDR_ALIGN[3:0]][vcg_pkg::BIT_ALIGN_EN];
  assign alignment_init_trigger_o = r.align_init;
  assign hsync_active_edge_o      = r.h_edge;
  assign frame_counter_h_reset_o  = r.h_rst;
  assign frame_counter_v_reset_o  = r.v_rst;
  assign frame_start_pulse_out_o  = r.frame_start_pulse_out;
  assign frame_start_pulse_oe_o   = ~r.regs[vcg_pkg::ADDR_OUT_CTRL[3:0]][vcg_pkg::BIT_TOF_FLOAT];

  // Checks
  assign status_rd  = read_byte(r, vcg_pkg::ADDR_STATUS);
  assign fb_high_rd = read_byte(r, vcg_pkg::ADDR_FB_HIGH);
  assign rsvd_rd    = read_byte(r, vcg_pkg::ADDR_RSVD);
  assign pump_rd    = read_byte(r, vcg_pkg::ADDR_PUMP);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_no_ref_inverse;
    arst_n_i && clk_en_i |=> no_reference_o != status_rd[vcg_pkg::BIT_REF_VALID]
      && no_reference_o == !($past(genlock_mode_i) && $past(ref_present_i));
  endproperty
  a_no_ref_inverse: assert property (p_no_ref_inverse) else $error("no-reference flag not inverse of status");

  property p_free_run_zero;
    arst_n_i && clk_en_i && !genlock_mode_i |=> !status_rd[vcg_pkg::BIT_REF_VALID] && no_reference_o;
  endproperty
  a_free_run_zero: assert property (p_free_run_zero) else $error("reference status set in free run");

  property p_ref_valid_follow;
    arst_n_i && clk_en_i && genlock_mode_i && ref_present_i |=> status_rd[vcg_pkg::BIT_REF_VALID];
  endproperty
  a_ref_valid_follow: assert property (p_ref_valid_follow) else $error("reference status missed");

  property p_lock_flags;
    arst_n_i && clk_en_i |=> status_rd[2:1] == {$past(hd_pll_locked_i), $past(sd_pll_locked_i)};
  endproperty
  a_lock_flags: assert property (p_lock_flags) else $error("lock flags do not follow PLLs");

  property p_fb_high_zero;
    fb_high_rd[7:5] == 3'h0 && feedback_divider_value_o[12:8] == fb_high_rd[4:0];
  endproperty
  a_fb_high_zero: assert property (p_fb_high_zero) else $error("feedback divider upper bits wrong");

  property p_pump_invert;
    {~sd_pll_pump_current_o[3], sd_pll_pump_current_o[2:0]} == pump_rd[3:0];
  endproperty
  a_pump_invert: assert property (p_pump_invert) else $error("pump current bit 3 not inverted");

  property p_init_on_rise;
    $past(clk_en_i) && $rose(r.regs[vcg_pkg::ADDR_ALIGN[3:0]][vcg_pkg::BIT_ALIGN_INIT]) |-> alignment_init_trigger_o;
  endproperty
  a_init_on_rise: assert property (p_init_on_rise) else $error("alignment trigger missing on rise");

  property p_pin_ignored;
    clk_en_i && e_rise[vcg_pkg::LANE_PIN] && !alignment_mode_enable_o && r.st == vcg_pkg::ST_IDLE
      |=> !alignment_init_trigger_o;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin pulse not ignored");

  property p_pin_selects;
    clk_en_i && !r.regs[vcg_pkg::ADDR_POLARITY[3:0]][vcg_pkg::BIT_PIN_OVRD] && !serial_reference_select_enable_i
      |=> reference_select_b_o == $past(select_pin_i);
  endproperty
  a_pin_selects: assert property (p_pin_selects) else $error("pin level does not select reference");

  property p_sync_reset_locked;
    frame_counter_h_reset_o || frame_counter_v_reset_o |-> $past(r.ref_valid) && $past(r.standard_def_pll_locked);
  endproperty
  a_sync_reset_locked: assert property (p_sync_reset_locked) else $error("frame reset while unlocked");

  property p_reserved_zero;
    rsvd_rd == 8'h00 && status_rd[7:3] == lock_threshold_o;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved register not zero");

  c_addr_ack: cover property (r.st == vcg_pkg::ST_ADDR ##1 r.st == vcg_pkg::ST_ACK);
  c_read_byte: cover property (r.st == vcg_pkg::ST_TX ##[1:200] r.st == vcg_pkg::ST_MACK);
  c_init: cover property (alignment_init_trigger_o);
  c_h_reset: cover property (frame_counter_h_reset_o);
endmodule

// ==== bench/vcg_host.sv ====
// Serial bus host model driving clock and data lines
`timescale 1ns/1ps
module vcg_host (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic half(input logic c, input logic d);
    @(posedge clk_sys_i);
    scl_o <= c;
    sda_o <= d;
    repeat (5) @(posedge clk_sys_i);
  endtask
  task automatic bitx(input logic d, output logic s);
    half(1'b0, sda_o);
    half(1'b0, d);
    half(1'b1, d);
    s = sda_i;
  endtask
  task automatic start();
    half(1'b0, sda_o);
    half(1'b0, 1'b1);
    half(1'b1, 1'b1);
    half(1'b1, 1'b0);
  endtask
  task automatic stop();
    half(1'b0, sda_o);
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
    half(1'b1, 1'b1);
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the genlock register bank
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, gl = 1'b1, rp = 1'b1, sdl = 1'b1, hdl = 1'b1, pin = 1'b0;
  logic [3:0] syn = 4'h0;
  logic       ce = 1'b1, sre = 1'b0, rsel = 1'b0, fs = 1'b0;
  logic       scl, hsda, oe, nref, trig;
  logic       sdo, rsb, crm, amen, fpo, fpoe, hev, hrs, vrs;
  logic [1:0] rdiv;
  logic [12:0] frr;
  vcg_pkg::vcg_outclk_s occ;
  wire        sda_w = hsda & (~oe | sdo);
  logic [12:0] fb;
  logic [3:0] pump;
  logic [4:0] thr;
  logic [7:0] ex [0:11] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'hb4, 8'h06, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00};
  int         err_total = 0, samples_checked = 0, pulses = 0, nh = 0, nhr = 0, nvr = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (trig === 1'b1) pulses <= pulses + 1;
  always @(posedge clk_sys_i) if (hev === 1'b1) nh <= nh + 1;
  always @(posedge clk_sys_i) if (hrs === 1'b1) nhr <= nhr + 1;
  always @(posedge clk_sys_i) if (vrs === 1'b1) nvr <= nvr + 1;
  vcg_host h (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
  vcg_regs dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(ce), .i2c_enable_n_i(1'b0),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sdo), .sda_oe_o(oe), .genlock_mode_i(gl), .ref_present_i(rp),
    .sd_pll_locked_i(sdl), .hd_pll_locked_i(hdl), .serial_reference_select_enable_i(sre),
    .reference_select_reg_i(rsel), .select_pin_i(pin), .sync_i(syn), .frame_start_i(fs),
    .no_reference_o(nref), .reference_select_b_o(rsb), .lock_threshold_o(thr), .clock_reference_mode_o(crm),
    .reference_divider_o(rdiv), .feedback_divider_value_o(fb), .sd_pll_pump_current_o(pump), .out_clk_ctrl_o(occ),
    .frame_counter_reset_ratio_o(frr), .alignment_mode_enable_o(amen), .alignment_init_trigger_o(trig),
    .hsync_active_edge_o(hev), .frame_counter_h_reset_o(hrs), .frame_counter_v_reset_o(vrs),
    .frame_start_pulse_out_o(fpo), .frame_start_pulse_oe_o(fpoe));
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [12:0] s, input logic [12:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] msk(input int a);
    case (a)
      1: return 8'hf8;
      2, 8: return 8'h3f;
      3: return 8'h03;
      4, 9, 10: return 8'hff;
      5: return 8'h1f;
      6: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction
  task automatic xb(input logic [7:0] b, input logic rd, input logic nk, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) h.bitx(b[i], r[i]);
    h.bitx(nk, a);
    if (!rd) check(13'(a), 13'h0);
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    logic [7:0] r;
    h.start();
    xb(8'h5a, 0, 1, r);
    xb(8'(a), 0, 1, r);
    xb(d, 0, 1, r);
    h.stop();
    ex[a] = d & msk(a);
  endtask
  task automatic rdall();
    logic [7:0] r;
    h.start();
    xb(8'h5a, 0, 1, r);
    xb(8'h01, 0, 1, r);
    h.start();
    xb(8'h5b, 0, 1, r);
    for (int a = 1; a < 12; a++) begin
      xb(8'hff, 1, a == 11, r);
      check(13'(r), 13'(a == 1 ? {ex[1][7:3], hdl, sdl, gl & rp} : ex[a]));
    end
    h.stop();
    check(13'(nref), 13'(!(gl && rp)));
    check(fb, {ex[5][4:0], ex[4]});
    check(13'(pump), 13'(ex[6][3:0] ^ 4'h8));
    check(13'(thr), 13'(ex[1][7:3]));
    check(13'(rdiv), 13'(ex[3][1:0]));
    check(13'(crm), 13'(ex[2][4]));
    check(13'(occ), 13'({ex[8][0], ex[8][1], ex[8][3:2], ex[8][4]}));
    check(13'(fpoe), 13'(!ex[8][5]));
    check(frr, {ex[10][4:0], ex[9]});
    check(13'(amen), 13'(ex[10][7]));
    check(13'(fpo), 13'(fs == ex[10][6]));
    check(13'(rsb), 13'((ex[2][5] || sre) ? rsel : pin));
  endtask
  task automatic pulse_pin();
    pin <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    pin <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    err_total++;
    conclude();
  end
  initial begin
    logic [7:0] d;
    int p, qh, qr, qv;
    d = 8'($urandom(32'h7540));
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rdall();
    for (int k = 0; k < 4; k++) begin
      {sre, fs, rsel, rp, sdl, hdl, syn} <= 10'($urandom);
      gl <= k[0];
      for (int a = 1; a < 12; a++) begin
        d = 8'($urandom);
        if (a == 2) d[4] = 1'b0;
        if (a == 6 && d[3:0] == 4'h8) d[3] = 1'b0;
        wr(a, d);
      end
      rdall();
    end
    wr(10, 8'h80);
    p = pulses;
    wr(10, 8'ha0);
    check(13'(pulses - p), 13'h1);
    wr(10, 8'ha0);
    check(13'(pulses - p), 13'h1);
    wr(2, 8'h20);
    pulse_pin();
    check(13'(pulses - p), 13'h2);
    wr(10, 8'h00);
    pulse_pin();
    check(13'(pulses - p), 13'h2);
    {gl, rp, sdl, sre, rsel, syn} <= {5'b11100, 4'hc};
    repeat (6) @(posedge clk_sys_i);
    qh = nh;
    qr = nhr;
    qv = nvr;
    syn <= 4'h0;
    repeat (6) @(posedge clk_sys_i);
    check(13'(nh - qh), 13'h1);
    check(13'(nhr - qr), 13'h1);
    check(13'(nvr - qv), 13'h1);
    ce <= 1'b0;
    rp <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    check(13'(nref), 13'h0);
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check(13'(nref), 13'h1);
    conclude();
  end
endmodule
